// *** include/bfp_pkg.sv ***
package bfp_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 10_000_000;
  // Delay times in microseconds, neutral defaults
  localparam int unsigned OVC_DET_US = 1000;
  localparam int unsigned OVD_DET_US = 1000;
  localparam int unsigned OVD_REL_US = 1000;
  localparam int unsigned OCR_DET_US = 100;
  localparam int unsigned OCR_REL_US = 1000;
  localparam int unsigned SHC_DET_US = 10;
  localparam int unsigned XCH_DET_US = 100;
  localparam int unsigned XCH_REL_US = 100;
  // Least times round down to whole cycles
  localparam int unsigned OVC_DET_CYC = (OVC_DET_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned OVD_DET_CYC = (OVD_DET_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned OVD_REL_CYC = (OVD_REL_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned OCR_DET_CYC = (OCR_DET_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned OCR_REL_CYC = (OCR_REL_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned SHC_DET_CYC = (SHC_DET_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned XCH_DET_CYC = (XCH_DET_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned XCH_REL_CYC = (XCH_REL_US * (CLOCK_HZ / 1_000_000));
  // Test mode divides counter delays by this shift
  localparam int unsigned TEST_SHIFT = 6;
  localparam int unsigned CNT_W = 16;

  // Sense node drive
  typedef enum logic [2:0] {
    BFP_NODE_FLOAT = 3'h1,
    BFP_NODE_PULLUP = 3'h2,
    BFP_NODE_PULLDN = 3'h4
  } bfp_node_e;
endpackage

// *** hdl/bfp_delay.sv ***
// Qualifying delay counter: done rises after cond has held for limit cycles
module bfp_delay #(
  parameter int unsigned CNT_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Condition and length
  input wire logic cond,
  input wire logic [CNT_W-1:0] limit,
  // Result
  output logic done
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic done_reg;
  logic done_next;

  // Count while the condition holds, clear when it drops
  always_comb begin
    count_next = count_reg;
    done_next = done_reg;
    if (!cond) begin
      count_next = '0;
      done_next = 1'b0;
    end else if (!done_reg) begin
      if (count_reg + 1'b1 >= limit) begin
        done_next = 1'b1;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

  a_delay_clears: assert property (@(posedge clock) disable iff (reset)
    !cond |=> !done) else $error("delay done without condition");
endmodule // bfp_delay

// *** hdl/bfp_core.sv ***
// Behaviour
// - An over-charge arising during over-discharge detection suspends it; over-charge wins.
// - Over-discharge detection restarts if its condition holds after over-charge is entered.
// - Over-discharge after over-charge gives no stand-by, only the supply pull-up on the node.
// - With over-current first, over-discharge and over-current run together and over-discharge runs on.
// - An over-discharge condition before any over-current suspends over-current detection.
// - After over-current the node pulls to ground; a later over-discharge swaps to pull-up and stand-by.
// - Over-discharge as first detection pulls the node up and enters stand-by.
// - Short-circuit detection runs regardless of every other detection.
// - Excessive-charger detection is inhibited during over-discharge, over-current or short.
// - The excessive-charger delay starts only after the discharge gate is high again.
// - Over-charge as first detection leaves the sense node floating.
// - The test input shortens counter delays but not the short-circuit delay.
module bfp_core #(
  parameter int unsigned CNT_W = bfp_pkg::CNT_W,
  parameter int unsigned OVC_DET_CYC = bfp_pkg::OVC_DET_CYC,
  parameter int unsigned OVD_DET_CYC = bfp_pkg::OVD_DET_CYC,
  parameter int unsigned OVD_REL_CYC = bfp_pkg::OVD_REL_CYC,
  parameter int unsigned OCR_DET_CYC = bfp_pkg::OCR_DET_CYC,
  parameter int unsigned OCR_REL_CYC = bfp_pkg::OCR_REL_CYC,
  parameter int unsigned SHC_DET_CYC = bfp_pkg::SHC_DET_CYC,
  parameter int unsigned XCH_DET_CYC = bfp_pkg::XCH_DET_CYC,
  parameter int unsigned XCH_REL_CYC = bfp_pkg::XCH_REL_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Comparator flags, asynchronous
  input wire logic ovc_cmp,
  input wire logic ovd_cmp,
  input wire logic ocr_cmp,
  input wire logic shc_cmp,
  input wire logic xch_cmp,
  input wire logic test_pin,
  // Gate drives
  output logic dis_gate,
  output logic chg_gate,
  // Sense node switches and mode
  output logic node_pullup,
  output logic node_pulldn,
  output logic standby
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] s1_reg, s2_reg, s3_reg, in_reg;
  logic [5:0] in_next;
  logic [5:0] pins;
  assign pins = {test_pin, xch_cmp, shc_cmp, ocr_cmp, ovd_cmp, ovc_cmp};

  // Accept a change once the second and third stages agree
  always_comb begin
    in_next = in_reg;
    for (int i = 0; i < 6; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        in_next[i] = s3_reg[i];
      end
    end
  end

  // Synchroniser registers
  always_ff @(posedge clock) begin
    if (reset) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
      s3_reg <= 6'h00;
      in_reg <= 6'h00;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      in_reg <= in_next;
    end
  end

  logic ovc_f, ovd_f, ocr_f, shc_f, xch_f, test_f;
  assign {test_f, xch_f, shc_f, ocr_f, ovd_f, ovc_f} = in_reg;

  // ---------------------------------------------------------------
  // Delay lengths
  // ---------------------------------------------------------------
  // Scale a counter delay, shortened in test mode, never below one
  function automatic logic [CNT_W-1:0] scaled(input int unsigned cyc, input logic tst);
    int unsigned v;
    v = tst ? (cyc >> bfp_pkg::TEST_SHIFT) : cyc;
    if (v < 1) v = 1;
    return CNT_W'(v);
  endfunction

  logic [CNT_W-1:0] lim_ovc, lim_ovd, lim_ovdr, lim_ocr, lim_ocrr, lim_shc, lim_xch, lim_xchr;
  assign lim_ovc = scaled(OVC_DET_CYC, test_f);
  assign lim_ovd = scaled(OVD_DET_CYC, test_f);
  assign lim_ovdr = scaled(OVD_REL_CYC, test_f);
  assign lim_ocr = scaled(OCR_DET_CYC, test_f);
  assign lim_ocrr = scaled(OCR_REL_CYC, test_f);
  assign lim_shc = scaled(SHC_DET_CYC, 1'b0);
  assign lim_xch = scaled(XCH_DET_CYC, test_f);
  assign lim_xchr = scaled(XCH_REL_CYC, test_f);

  // ---------------------------------------------------------------
  // Detection state
  // ---------------------------------------------------------------
  logic ovc_reg, ovd_reg, ocr_reg, shc_reg, xch_reg;
  logic ovc_next, ovd_next, ocr_next, shc_next, xch_next;
  logic ocr_first_reg, ocr_first_next;
  logic ovc_first_reg, ovc_first_next;

  // Run conditions for the ovd, ocr and xch counters
  logic ovd_run, ocr_run, xch_run;
  logic ovc_dn, ovd_dn, ovdr_dn, ocr_dn, ocrr_dn, shc_dn, xch_dn, xchr_dn;
  // Over-discharge waits while over-charge is pending but not yet entered
  assign ovd_run = ovd_f && !ovd_reg && !(ovc_f && !ovc_reg);
  // Over-current suspended once over-discharge condition came first
  assign ocr_run = ocr_f && !ocr_reg && !(ovd_f && !ocr_first_reg);
  // Excessive charger only with the discharge gate high and no discharge fault
  assign xch_run = xch_f && !xch_reg && dis_gate && !ovd_reg && !ocr_reg && !shc_reg;

  bfp_delay #(.CNT_W(CNT_W)) u_ovc (.clock(clock), .reset(reset),
    .cond(ovc_f && !ovc_reg), .limit(lim_ovc), .done(ovc_dn));
  bfp_delay #(.CNT_W(CNT_W)) u_ovd (.clock(clock), .reset(reset),
    .cond(ovd_run), .limit(lim_ovd), .done(ovd_dn));
  bfp_delay #(.CNT_W(CNT_W)) u_ovdr (.clock(clock), .reset(reset),
    .cond(ovd_reg && !ovd_f), .limit(lim_ovdr), .done(ovdr_dn));
  bfp_delay #(.CNT_W(CNT_W)) u_ocr (.clock(clock), .reset(reset),
    .cond(ocr_run), .limit(lim_ocr), .done(ocr_dn));
  bfp_delay #(.CNT_W(CNT_W)) u_ocrr (.clock(clock), .reset(reset),
    .cond((ocr_reg || shc_reg) && !ocr_f && !shc_f), .limit(lim_ocrr), .done(ocrr_dn));
  bfp_delay #(.CNT_W(CNT_W)) u_shc (.clock(clock), .reset(reset),
    .cond(shc_f && !shc_reg), .limit(lim_shc), .done(shc_dn));
  bfp_delay #(.CNT_W(CNT_W)) u_xch (.clock(clock), .reset(reset),
    .cond(xch_run), .limit(lim_xch), .done(xch_dn));
  bfp_delay #(.CNT_W(CNT_W)) u_xchr (.clock(clock), .reset(reset),
    .cond(xch_reg && !xch_f), .limit(lim_xchr), .done(xchr_dn));

  // Next detection state
  always_comb begin
    ovc_next = ovc_reg;
    ovd_next = ovd_reg;
    ocr_next = ocr_reg;
    shc_next = shc_reg;
    xch_next = xch_reg;
    ocr_first_next = ocr_first_reg;
    ovc_first_next = ovc_first_reg;
    if (ovc_dn) begin
      ovc_next = 1'b1;
      ovc_first_next = !ovd_reg && !ocr_reg;
    end else if (ovc_reg && !ovc_f) begin
      ovc_next = 1'b0;
    end
    if (ovd_dn) begin
      ovd_next = 1'b1;
    end else if (ovdr_dn) begin
      ovd_next = 1'b0;
    end
    if (ocr_dn) begin
      ocr_next = 1'b1;
    end else if (ocrr_dn) begin
      ocr_next = 1'b0;
    end
    if (shc_dn) begin
      shc_next = 1'b1;
    end else if (ocrr_dn) begin
      shc_next = 1'b0;
    end
    // A discharge fault in effect beats a detection still in flight
    if (ovd_reg || ocr_reg || shc_reg) begin
      xch_next = 1'b0;
    end else if (xch_dn) begin
      xch_next = 1'b1;
    end else if (xchr_dn) begin
      xch_next = 1'b0;
    end
    // Remember whether over-current came before over-discharge
    if (!ocr_f && !ocr_reg) begin
      ocr_first_next = 1'b0;
    end else if (ocr_f && !ovd_f) begin
      ocr_first_next = 1'b1;
    end
  end

  // Detection registers
  always_ff @(posedge clock) begin
    if (reset) begin
      ovc_reg <= 1'b0;
      ovd_reg <= 1'b0;
      ocr_reg <= 1'b0;
      shc_reg <= 1'b0;
      xch_reg <= 1'b0;
      ocr_first_reg <= 1'b0;
      ovc_first_reg <= 1'b0;
    end else begin
      ovc_reg <= ovc_next;
      ovd_reg <= ovd_next;
      ocr_reg <= ocr_next;
      shc_reg <= shc_next;
      xch_reg <= xch_next;
      ocr_first_reg <= ocr_first_next;
      ovc_first_reg <= ovc_first_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  bfp_pkg::bfp_node_e node_next;
  logic dis_next, chg_next, stby_next;

  // Gate and sense node decision
  always_comb begin
    dis_next = !(ovd_reg || ocr_reg || shc_reg);
    chg_next = !(ovc_reg || xch_reg);
    stby_next = 1'b0;
    node_next = bfp_pkg::BFP_NODE_FLOAT;
    if (ovd_reg) begin
      node_next = bfp_pkg::BFP_NODE_PULLUP;
      stby_next = !ovc_reg;
    end else if (ovc_reg && ovc_first_reg) begin
      node_next = bfp_pkg::BFP_NODE_FLOAT;
    end else if (ocr_reg || shc_reg) begin
      node_next = bfp_pkg::BFP_NODE_PULLDN;
    end
  end

  // Output registers
  always_ff @(posedge clock) begin
    if (reset) begin
      dis_gate <= 1'b1;
      chg_gate <= 1'b1;
      node_pullup <= 1'b0;
      node_pulldn <= 1'b0;
      standby <= 1'b0;
    end else begin
      dis_gate <= dis_next;
      chg_gate <= chg_next;
      node_pullup <= (node_next == bfp_pkg::BFP_NODE_PULLUP);
      node_pulldn <= (node_next == bfp_pkg::BFP_NODE_PULLDN);
      standby <= stby_next;
    end
  end

  // ---------------------------------------------------------------
  // Check helpers
  // ---------------------------------------------------------------
  // Ages of the short condition and of the high discharge gate
  logic [CNT_W-1:0] shc_age_reg, shc_age_next;
  logic [CNT_W-1:0] gate_age_reg, gate_age_next;

  // Saturating increment, so a long level never wraps to a short age
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] val);
    return (&val) ? val : val + 1'b1;
  endfunction

  // Count unbroken cycles of each level, restart at zero when it drops
  always_comb begin
    shc_age_next = '0;
    gate_age_next = '0;
    if (shc_f && !shc_reg) begin
      shc_age_next = sat_inc(shc_age_reg);
    end
    if (dis_gate) begin
      gate_age_next = sat_inc(gate_age_reg);
    end
  end

  // Age registers
  always_ff @(posedge clock) begin
    if (reset) begin
      shc_age_reg <= '0;
      gate_age_reg <= '0;
    end else begin
      shc_age_reg <= shc_age_next;
      gate_age_reg <= gate_age_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_node_exclusive: assert property (@(posedge clock) disable iff (reset)
    !(node_pullup && node_pulldn)) else $error("both node paths on");
  a_ovd_standby: assert property (@(posedge clock) disable iff (reset)
    (ovd_reg && !ovc_reg) |=> (standby && node_pullup)) else $error("no stand-by");
  a_ovc_nostby: assert property (@(posedge clock) disable iff (reset)
    (ovd_reg && ovc_reg) |=> (!standby && node_pullup)) else $error("stand-by in overcharge");
  a_ovd_held: assert property (@(posedge clock) disable iff (reset)
    (ovc_f && !ovc_reg && !ovd_dn) |=> !ovd_dn) else $error("ovd counted while ovc pending");
  a_ocr_suspend: assert property (@(posedge clock) disable iff (reset)
    (ovd_f && !ocr_first_reg && !ocr_dn) |=> !ocr_dn) else $error("ocr counted after ovd");
  a_ovd_parallel: assert property (@(posedge clock) disable iff (reset)
    (ocr_reg && ovd_f && !ovd_reg && !ovc_f) |-> ovd_run) else $error("ovd blocked");
  a_shc_free: assert property (@(posedge clock) disable iff (reset)
    shc_dn |=> shc_reg) else $error("short detection blocked");
  a_shc_gate: assert property (@(posedge clock) disable iff (reset)
    shc_reg |=> !dis_gate) else $error("gate on during short");
  a_xch_inhibit: assert property (@(posedge clock) disable iff (reset)
    (ovd_reg || ocr_reg || shc_reg) |=> !xch_reg) else $error("xch during fault");
  a_xch_gate: assert property (@(posedge clock) disable iff (reset)
    $rose(xch_reg) |-> ($past(gate_age_reg) >= lim_xch)) else $error("xch before gate high");
  a_ovc_float: assert property (@(posedge clock) disable iff (reset)
    (ovc_reg && ovc_first_reg && !ovd_reg) |=> (!node_pullup && !node_pulldn))
    else $error("node not released");
  a_ocr_pulldn: assert property (@(posedge clock) disable iff (reset)
    (ocr_reg && !ovd_reg && !ovc_reg) |=> (node_pulldn && !standby))
    else $error("no ground pull");
  a_test_short: assert property (@(posedge clock) disable iff (reset)
    $rose(shc_dn) |-> (shc_age_reg >= CNT_W'(SHC_DET_CYC))) else $error("shc shortened");
endmodule // bfp_core

// *** dv/bfp_cell_model.sv ***
// Cells, load and charger as seen by the comparators
module bfp_cell_model (
  // Conditions set by the bench
  input wire logic over_v,
  input wire logic under_v,
  input wire logic heavy_load,
  input wire logic short_load,
  input wire logic charger_hi,
  // Discharge gate from the device
  input wire logic dis_gate,
  // Comparator flags
  output logic ovc_cmp,
  output logic ovd_cmp,
  output logic ocr_cmp,
  output logic shc_cmp,
  output logic xch_cmp
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Comparator levels
  // ---------------------------------------------------------------
  // Cell and load levels
  assign ovc_cmp = over_v;
  assign ovd_cmp = under_v;
  assign ocr_cmp = heavy_load;
  assign shc_cmp = short_load;
  // Gate off: charge flows via body diode, node sits near -Vf
  assign xch_cmp = charger_hi & dis_gate;
endmodule // bfp_cell_model

// *** dv/tb.sv ***
// Self-checking bench for the fault priority core
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 120;
  typedef struct packed {logic [4:0] cond; logic [4:0] outs;} bfp_row_s;
  logic clock, reset, test_pin;
  logic over_v, under_v, heavy_load, short_load, charger_hi;
  logic ovc_cmp, ovd_cmp, ocr_cmp, shc_cmp, xch_cmp;
  logic dis_gate, chg_gate, node_pullup, node_pulldn, standby;
  int bad_count, comparisons, cycles;
  bfp_row_s rows [6];
  // ---------------------------------------------------------------
  // Clock, far side and device
  // ---------------------------------------------------------------
  // Free running 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  bfp_cell_model u_cells (.over_v(over_v), .under_v(under_v), .heavy_load(heavy_load),
    .short_load(short_load), .charger_hi(charger_hi), .dis_gate(dis_gate),
    .ovc_cmp(ovc_cmp), .ovd_cmp(ovd_cmp), .ocr_cmp(ocr_cmp), .shc_cmp(shc_cmp),
    .xch_cmp(xch_cmp));
  // Short delay, over-current and charger releases keep their defaults; short then takes 100 cycles
  bfp_core #(.OVC_DET_CYC(12), .OVD_DET_CYC(8), .OVD_REL_CYC(8), .OCR_DET_CYC(4),
    .XCH_DET_CYC(8)) u_dut (
    .clock(clock), .reset(reset), .ovc_cmp(ovc_cmp), .ovd_cmp(ovd_cmp), .ocr_cmp(ocr_cmp),
    .shc_cmp(shc_cmp), .xch_cmp(xch_cmp), .test_pin(test_pin), .dis_gate(dis_gate),
    .chg_gate(chg_gate), .node_pullup(node_pullup), .node_pulldn(node_pulldn),
    .standby(standby));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Verdict and end of run
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Conditions {over_v, under_v, heavy_load, short_load, charger_hi}
  task automatic apply(input logic [4:0] c);
    @(posedge clock);
    {over_v, under_v, heavy_load, short_load, charger_hi} <= c;
  endtask
  // Outputs {dis_gate, chg_gate, node_pullup, node_pulldn, standby}, masked
  task automatic check_outs(input string name, input logic [4:0] exp, input logic [4:0] mask);
    logic [4:0] got;
    @(negedge clock);
    got = {dis_gate, chg_gate, node_pullup, node_pulldn, standby} & mask;
    comparisons++;
    if (got !== (exp & mask)) begin
      $display("Error %s expected %h seen %h", name, exp & mask, got);
      bad_count++;
    end
  endtask
  task automatic hold(input string name, input int n, input logic [4:0] exp,
      input logic [4:0] mask);
    repeat (n) check_outs(name, exp, mask);
  endtask
  task automatic restart();
    apply(5'h00);
    reset <= 1'b1;
    test_pin <= 1'b0;
    tick(2);
    reset <= 1'b0;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 3000) begin
      bad_count++;
      $display("Error timeout expected end seen hang");
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {over_v, under_v, heavy_load, short_load, charger_hi} = 5'h00;
    reset = 1'b1;
    test_pin = 1'b0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    rows[0] = '{5'h00, 5'h18};
    rows[1] = '{5'h10, 5'h10};
    rows[2] = '{5'h08, 5'h0d};
    rows[3] = '{5'h04, 5'h0a};
    rows[4] = '{5'h02, 5'h0a};
    rows[5] = '{5'h01, 5'h10};
    tick(8);
    reset <= 1'b0;
    // Single conditions from a clean start
    for (int i = 0; i < 6; i++) begin
      restart();
      apply(rows[i].cond);
      tick(SETTLE);
      check_outs("single", rows[i].outs, 5'h1f);
      $display("Test row %0d done", i);
    end
    // Reset in mid-run while the charge gate is off
    tick(1);
    reset <= 1'b1;
    tick(1);
    check_outs("reset", 5'h18, 5'h1f);
    $display("Test mid reset done");
    // Discharge first, current second: no ground pull ever
    restart();
    apply(5'h08);
    apply(5'h0c);
    hold("no_pulldn", SETTLE, 5'h00, 5'h02);
    check_outs("ovd_first", 5'h0d, 5'h1f);
    $display("Test discharge first done");
    // Current first, discharge second
    restart();
    apply(5'h04);
    tick(SETTLE);
    check_outs("ocr_first", 5'h0a, 5'h1f);
    apply(5'h0c);
    tick(SETTLE);
    check_outs("ocr_then_ovd", 5'h0d, 5'h1f);
    $display("Test current first done");
    // Over-charge during discharge delay
    restart();
    apply(5'h08);
    apply(5'h18);
    hold("ovd_paused", 16, 5'h10, 5'h10);
    tick(SETTLE);
    check_outs("ovd_resumed", 5'h04, 5'h1f);
    $display("Test over-charge priority done");
    // Charger while discharge gate is off
    restart();
    apply(5'h09);
    tick(SETTLE);
    check_outs("xch_blocked", 5'h0d, 5'h1f);
    apply(5'h01);
    for (int i = 0; i < 60 && dis_gate !== 1'b1; i++) @(negedge clock);
    tick(3);
    check_outs("xch_wait", 5'h18, 5'h18);
    tick(SETTLE);
    check_outs("xch_late", 5'h10, 5'h1f);
    $display("Test charger after gate done");
    // Test input: counter delays short, short-circuit not
    restart();
    test_pin <= 1'b1;
    apply(5'h08);
    tick(11);
    check_outs("test_ovd", 5'h00, 5'h10);
    restart();
    test_pin <= 1'b1;
    apply(5'h02);
    tick(11);
    check_outs("test_shc", 5'h10, 5'h10);
    tick(SETTLE);
    check_outs("test_shc_end", 5'h0a, 5'h1f);
    $display("Test shortened delays done");
    // Short pulses must not add up
    restart();
    repeat (3) begin
      apply(5'h08);
      hold("pulse_hi", 7, 5'h10, 5'h10);
      apply(5'h00);
      hold("pulse_lo", 4, 5'h10, 5'h10);
    end
    $display("Test counter clear done");
    conclude();
  end
endmodule // tb
